// File: common/cit_pkg.sv
// constants and types shared by the capture interval timer
package cit_pkg;
  localparam int CIT_W = 8;
  localparam int CIT_PRESC_W = 6;
  localparam int CIT_FILT_LEN = 5;
  localparam logic [CIT_W-1:0] CIT_COUNT_RST = 8'h00;
  localparam logic [CIT_PRESC_W-1:0] CIT_PRESC_RST = 6'h00;
  localparam logic [CIT_PRESC_W-1:0] CIT_PRESC_ONE = 6'h01;
  localparam logic [CIT_W-1:0] CIT_COUNT_ONE = 8'h01;
  // prescaler bit whose level is the divided clock
  localparam int CIT_BIT_DIV64 = 5;
  localparam int CIT_BIT_DIV32 = 4;
  localparam int CIT_BIT_DIV2 = 0;
  localparam logic [CIT_FILT_LEN-1:0] CIT_FILT_ONES = 5'h1F;
  localparam logic [CIT_FILT_LEN-1:0] CIT_FILT_ZEROS = 5'h00;

  typedef enum logic [1:0] {
    CIT_CLK_DIV64 = 2'h0,
    CIT_CLK_DIV32 = 2'h1,
    CIT_CLK_DIV2 = 2'h2,
    CIT_CLK_WATCH4 = 2'h3
  } cit_clk_sel_t;

  typedef enum logic [1:0] {
    CIT_CLR_NONE = 2'h0,
    CIT_CLR_FALL = 2'h1,
    CIT_CLR_RISE = 2'h2,
    CIT_CLR_BOTH = 2'h3
  } cit_clr_sel_t;

  typedef enum logic [2:0] {
    CIT_PM_ACTIVE = 3'h0,
    CIT_PM_SLEEP = 3'h1,
    CIT_PM_WATCH = 3'h2,
    CIT_PM_SUBACTIVE = 3'h3,
    CIT_PM_SUBSLEEP = 3'h4,
    CIT_PM_STANDBY = 3'h5,
    CIT_PM_MODULE_STANDBY = 3'h6
  } cit_power_mode_t;

  typedef enum logic [1:0] {
    CIT_SUB_W8 = 2'h0,
    CIT_SUB_W4 = 2'h1,
    CIT_SUB_W2 = 2'h2
  } cit_sub_rate_t;

  // timer_mode_reg fields plus port mode bits
  typedef struct packed {
    cit_clk_sel_t clock_select;
    cit_clr_sel_t clear_select;
    logic capture_edge_select;
    logic capture_pin_select;
    logic filter_select;
  } cit_cfg_t;

  typedef struct packed {
    logic [CIT_W-1:0] capture_timer_count;
    logic [CIT_W-1:0] rise_capture_reg;
    logic [CIT_W-1:0] fall_capture_reg;
  } cit_values_t;
endpackage : cit_pkg

// File: logic/cit_capture_interval_timer.sv
// eight-bit capture / interval timer with input filter
`timescale 1ns/1ps
module cit_capture_interval_timer
  import cit_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic capture_pin,
  input wire logic watch_clk_div4,
  input cit_power_mode_t power_mode,
  input cit_sub_rate_t sub_rate,
  input cit_cfg_t cfg,
  input wire logic timer_irq_clear,
  output cit_values_t values,
  output logic capture_signal,
  output logic timer_irq_flag
);

  // watch clock synchroniser, first stage read only by second
  logic wclk_meta_q, wclk_meta_d;
  logic wclk_sync_q, wclk_sync_d;
  logic [CIT_PRESC_W-1:0] presc_q, presc_d;
  logic sel_clk_prev_q, sel_clk_prev_d;
  logic [CIT_FILT_LEN-1:0] filt_q, filt_d;
  logic filt_out_q, filt_out_d;
  logic cap_prev_q, cap_prev_d;
  logic [CIT_W-1:0] count_q, count_d;
  logic [CIT_W-1:0] rise_q, rise_d;
  logic [CIT_W-1:0] fall_q, fall_d;
  logic irq_q, irq_d;

  logic running;
  logic sel_clk;
  logic clk_fall;
  logic clk_rise;
  logic sample_en;
  logic cap_sig;
  logic edge_rise;
  logic edge_fall;
  logic clear_hit;
  logic irq_hit;

  // two-stage synchroniser for the asynchronous watch clock
  always_comb begin
    wclk_meta_d = watch_clk_div4;
    wclk_sync_d = wclk_meta_q;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wclk_meta_q <= 1'b0;
      wclk_sync_q <= 1'b0;
    end else begin
      wclk_meta_q <= wclk_meta_d;
      wclk_sync_q <= wclk_sync_d;
    end
  end

  // operating conditions per power mode
  always_comb begin
    case (power_mode)
      CIT_PM_ACTIVE, CIT_PM_SLEEP: running = 1'b1;
      CIT_PM_WATCH: running = (cfg.clock_select == CIT_CLK_WATCH4);
      CIT_PM_SUBACTIVE, CIT_PM_SUBSLEEP: begin
        running = (cfg.clock_select == CIT_CLK_WATCH4) && (sub_rate == CIT_SUB_W2);
      end
      default: running = 1'b0;
    endcase
  end

  // selected internal clock level
  always_comb begin
    case (cfg.clock_select)
      CIT_CLK_DIV64: sel_clk = presc_q[CIT_BIT_DIV64];
      CIT_CLK_DIV32: sel_clk = presc_q[CIT_BIT_DIV32];
      CIT_CLK_DIV2: sel_clk = presc_q[CIT_BIT_DIV2];
      CIT_CLK_WATCH4: sel_clk = wclk_sync_q;
      default: sel_clk = presc_q[CIT_BIT_DIV64];
    endcase
  end

  // previous level is of the old source, so a switch high to low counts
  assign clk_fall = sel_clk_prev_q && !sel_clk;
  assign clk_rise = !sel_clk_prev_q && sel_clk;
  // filtered: sample on rising edge of internal clock; else every system clock
  assign sample_en = cfg.filter_select ? clk_rise : 1'b1;

  // internal capture signal
  always_comb begin
    if (!cfg.capture_pin_select) begin
      cap_sig = 1'b0;
    end else if (cfg.filter_select) begin
      cap_sig = filt_out_q;
    end else begin
      cap_sig = capture_pin;
    end
  end

  assign edge_rise = running && !cap_prev_q && cap_sig;
  assign edge_fall = running && cap_prev_q && !cap_sig;

  always_comb begin
    case (cfg.clear_select)
      CIT_CLR_FALL: clear_hit = edge_fall;
      CIT_CLR_RISE: clear_hit = edge_rise;
      CIT_CLR_BOTH: clear_hit = edge_rise || edge_fall;
      default: clear_hit = 1'b0;
    endcase
  end

  assign irq_hit = cfg.capture_edge_select ? edge_rise : edge_fall;

  // prescaler, filter, counter and capture next values
  always_comb begin
    presc_d = presc_q;
    sel_clk_prev_d = sel_clk_prev_q;
    filt_d = filt_q;
    filt_out_d = filt_out_q;
    cap_prev_d = cap_prev_q;
    count_d = count_q;
    rise_d = rise_q;
    fall_d = fall_q;
    if (running) begin
      presc_d = presc_q + CIT_PRESC_ONE;
      sel_clk_prev_d = sel_clk;
      cap_prev_d = cap_sig;
      if (sample_en) begin
        filt_d = {filt_q[CIT_FILT_LEN-2:0], capture_pin};
        if (filt_q == CIT_FILT_ONES) begin
          filt_out_d = 1'b1;
        end else if (filt_q == CIT_FILT_ZEROS) begin
          filt_out_d = 1'b0;
        end
      end
      if (clear_hit) begin
        count_d = CIT_COUNT_RST;
      end else if (clk_fall) begin
        count_d = count_q + CIT_COUNT_ONE;
      end
      if (edge_rise) begin
        rise_d = count_q;
      end
      if (edge_fall) begin
        fall_d = count_q;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      presc_q <= CIT_PRESC_RST;
      sel_clk_prev_q <= 1'b0;
      filt_q <= CIT_FILT_ZEROS;
      filt_out_q <= 1'b0;
      cap_prev_q <= 1'b0;
      count_q <= CIT_COUNT_RST;
      rise_q <= CIT_COUNT_RST;
      fall_q <= CIT_COUNT_RST;
    end else begin
      presc_q <= presc_d;
      sel_clk_prev_q <= sel_clk_prev_d;
      filt_q <= filt_d;
      filt_out_q <= filt_out_d;
      cap_prev_q <= cap_prev_d;
      count_q <= count_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  // request flag: set wins over a clear in the same cycle
  always_comb begin
    irq_d = irq_q;
    if (timer_irq_clear) begin
      irq_d = 1'b0;
    end
    if (irq_hit) begin
      irq_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // capture signal leaves one clock after the internal signal while running, and holds its level while halted
  assign values.capture_timer_count = count_q;
  assign values.rise_capture_reg = rise_q;
  assign values.fall_capture_reg = fall_q;
  assign capture_signal = cap_prev_q;
  assign timer_irq_flag = irq_q;

endmodule : cit_capture_interval_timer

// File: test/cit_checker.sv
// port assertions for the capture interval timer
`timescale 1ns/1ps
module cit_checker
  import cit_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input cit_power_mode_t power_mode,
  input cit_cfg_t cfg,
  input wire logic timer_irq_clear,
  input cit_values_t values,
  input logic capture_signal,
  input logic timer_irq_flag
);
  logic [7:0] cnt;
  logic cs;
  assign cnt = values.capture_timer_count;
  assign cs = capture_signal;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  property p_rcap; $rose(cs) |-> values.rise_capture_reg == $past(cnt); endproperty
  a_rcap: assert property (p_rcap) else $error("rise capture");
  property p_fcap; $fell(cs) |-> values.fall_capture_reg == $past(cnt); endproperty
  a_fcap: assert property (p_fcap) else $error("fall capture");
  property p_clr; $changed(cs) && $past(cfg.clear_select) == CIT_CLR_BOTH |-> cnt == 8'h00;
  endproperty
  a_clr: assert property (p_clr) else $error("no clear");
  property p_inc; $changed(cnt) && !$changed(cs) |-> cnt == $past(cnt) + 8'h01; endproperty
  a_inc: assert property (p_inc) else $error("bad step");
  property p_irq; $rose(cs) && $past(cfg.capture_edge_select) |-> timer_irq_flag; endproperty
  a_irq: assert property (p_irq) else $error("no flag");
  property p_hold; timer_irq_flag && !timer_irq_clear |=> timer_irq_flag; endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_sel; !cfg.capture_pin_select |=> !cs; endproperty
  a_sel: assert property (p_sel) else $error("signal not low");
  property p_stop; power_mode == CIT_PM_WATCH && cfg.clock_select != CIT_CLK_WATCH4
    |=> $stable(values); endproperty
  a_stop: assert property (p_stop) else $error("not halted");
endmodule : cit_checker

// File: test/cit_pulse_src.sv
// capture pin source model
`timescale 1ns/1ps
module cit_pulse_src (
  input wire logic clk_sys,
  input wire logic level_req,
  output logic capture_pin
);
  always_ff @(posedge clk_sys) begin
    capture_pin <= level_req;
  end
endmodule : cit_pulse_src

// File: test/tb_cit_capture_interval_timer.sv
// self-checking bench for the capture interval timer
`timescale 1ns/1ps
module tb_cit_capture_interval_timer
  import cit_pkg::*;
;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic level_req = 1'b0;
  logic timer_irq_clear = 1'b0;
  logic watch_clk_div4 = 1'b0;
  cit_sub_rate_t sub_rate = CIT_SUB_W2;
  logic capture_pin, capture_signal, timer_irq_flag;
  cit_power_mode_t power_mode = CIT_PM_ACTIVE;
  cit_cfg_t cfg = '0;
  cit_values_t values;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  cit_pulse_src src (.clk_sys(clk_sys), .level_req(level_req), .capture_pin(capture_pin));
  cit_capture_interval_timer uut (.clk_sys(clk_sys), .srst(srst), .capture_pin(capture_pin),
    .watch_clk_div4(watch_clk_div4), .power_mode(power_mode), .sub_rate(sub_rate), .cfg(cfg),
    .timer_irq_clear(timer_irq_clear), .values(values), .capture_signal(capture_signal),
    .timer_irq_flag(timer_irq_flag));
  initial forever #5 clk_sys = ~clk_sys;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : step
  task automatic close_out();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      close_out();
    end
  end
  initial begin
    step(3);
    srst <= 1'b0;
    step(140);
    @(negedge clk_sys);
    chk(values.capture_timer_count, 8'h02);
    step(1);
    cfg <= '{CIT_CLK_DIV2, CIT_CLR_BOTH, 1'b1, 1'b1, 1'b0};
    step(1);
    level_req <= 1'b1;
    step(21);
    level_req <= 1'b0;
    step(11);
    level_req <= 1'b1;
    step(4);
    @(negedge clk_sys);
    chk(values.fall_capture_reg, 8'h0A);
    chk(values.rise_capture_reg, 8'h05);
    chk({7'h00, timer_irq_flag}, 8'h01);
    step(1);
    timer_irq_clear <= 1'b1;
    step(1);
    timer_irq_clear <= 1'b0;
    cfg.capture_pin_select <= 1'b0;
    step(2);
    @(negedge clk_sys);
    chk({7'h00, capture_signal}, 8'h00);
    chk(values.fall_capture_reg, 8'h02);
    chk({7'h00, timer_irq_flag}, 8'h00);
    step(1);
    cfg.capture_pin_select <= 1'b1;
    step(2);
    @(negedge clk_sys);
    chk({7'h00, capture_signal}, 8'h01);
    chk(values.rise_capture_reg, 8'h01);
    chk({7'h00, timer_irq_flag}, 8'h01);
    step(1);
    // halted source: pin moves but nothing is captured until the watch clock is selected
    power_mode <= CIT_PM_WATCH;
    level_req <= 1'b0;
    step(20);
    @(negedge clk_sys);
    chk({7'h00, capture_signal}, 8'h01);
    step(1);
    cfg.clock_select <= CIT_CLK_WATCH4;
    step(6);
    @(negedge clk_sys);
    chk({7'h00, capture_signal}, 8'h00);
    chk(values.fall_capture_reg, 8'h01);
    chk(values.rise_capture_reg, 8'h01);
    // sub mode with a slow subclock: halted, then running on w2
    step(1);
    power_mode <= CIT_PM_SUBACTIVE;
    sub_rate <= CIT_SUB_W4;
    watch_clk_div4 <= 1'b1;
    step(4);
    watch_clk_div4 <= 1'b0;
    step(4);
    @(negedge clk_sys);
    chk(values.capture_timer_count, 8'h00);
    step(1);
    sub_rate <= CIT_SUB_W2;
    watch_clk_div4 <= 1'b1;
    step(4);
    watch_clk_div4 <= 1'b0;
    step(4);
    @(negedge clk_sys);
    chk(values.capture_timer_count, 8'h01);
    // filtered input: pin deselected before the filter changes
    step(1);
    power_mode <= CIT_PM_ACTIVE;
    timer_irq_clear <= 1'b1;
    cfg.capture_pin_select <= 1'b0;
    step(1);
    timer_irq_clear <= 1'b0;
    cfg <= '{CIT_CLK_DIV2, CIT_CLR_RISE, 1'b0, 1'b0, 1'b1};
    level_req <= 1'b1;
    step(20);
    @(negedge clk_sys);
    chk({7'h00, capture_signal}, 8'h00);
    chk({7'h00, timer_irq_flag}, 8'h00);
    step(1);
    cfg.capture_pin_select <= 1'b1;
    step(2);
    @(negedge clk_sys);
    chk({7'h00, capture_signal}, 8'h01);
    chk({7'h00, timer_irq_flag}, 8'h00);
    step(1);
    level_req <= 1'b0;
    step(3);
    level_req <= 1'b1;
    step(12);
    @(negedge clk_sys);
    chk({7'h00, capture_signal}, 8'h01);
    step(1);
    cfg.capture_pin_select <= 1'b0;
    step(2);
    @(negedge clk_sys);
    chk({7'h00, capture_signal}, 8'h00);
    chk(values.fall_capture_reg, 8'h09);
    chk({7'h00, timer_irq_flag}, 8'h01);
    step(10);
    timer_irq_clear <= 1'b1;
    step(1);
    timer_irq_clear <= 1'b0;
    step(2);
    @(negedge clk_sys);
    chk({7'h00, timer_irq_flag}, 8'h00);
    close_out();
  end
endmodule : tb_cit_capture_interval_timer

bind cit_capture_interval_timer cit_checker u_chk (.clk_sys(clk_sys), .srst(srst),
  .power_mode(power_mode), .cfg(cfg), .timer_irq_clear(timer_irq_clear), .values(values),
  .capture_signal(capture_signal), .timer_irq_flag(timer_irq_flag));
